// *** design/plsd_decoder.sv ***
// plsd_decoder: latch decode and digital control of an integer-N synthesizer
// assumes pins (serial clock, data, latch strobe, chip enable, reference, phase
// error flag) arrive asynchronously and are synchronised here in two flip-flops
//
// Overview of operation
// - power-down bit set, sync bit clear: power down at once
// - both power-down bits set: power down on second reference edge after strobe
// - chip enable low disables device regardless of power-down bits
// - power-down loads counters, tristates pump, clears lock, stops reference buffer
// - current set one from low three bits, set two from high three
// - mute-until-locked keeps rf outputs off until lock
// - gain bit one picks current set two, zero picks set one
// - tristate bit one puts charge pump in high impedance
// - polarity bit one positive, zero negative detector polarity
// - divider reset bit holds r, a and b counters in reset
// - five-bit swallow count, range zero to thirty-one
// - thirteen-bit main count, three to 8191; host avoids lower values
// - feedback ratio is prescaler times main count plus swallow count
// - one gain flop, written by feedback bit 21 or control bit 10
// - feedback bit 22 enables output halving
// - feedback bit 23 routes halved output to prescaler
// - select bits zero,one address the reference divider word
// - fourteen-bit reference ratio accepts one to 16383
// - lock precision one needs five good cycles, zero needs three
// - test enable zero ignores test word; reserved bits kept zero
// - band clock divider sits between reference output and band logic
// - select bits zero,zero address the control word
// - 24 bits shift on serial rising edges, transfer on strobe rise
`timescale 1ns/1ps
module plsd_decoder
	import plsd_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         serial_clock_pin,
	input  wire logic         serial_data_pin,
	input  wire logic         serial_latch_strobe,
	input  wire logic         chip_enable_pin,
	input  wire logic         ref_out_pin,
	input  wire logic         phase_err_small_pin,
	output logic              powered_down,
	output logic              pump_tristate_out,
	output logic              pump_polarity_pos,
	output logic [2:0]        pump_current_sel,
	output logic              rf_output_enable,
	output logic              ref_buffer_enable,
	output logic              counters_load,
	output logic              lock_detect,
	output logic [1:0]        output_power_level,
	output logic [1:0]        core_power_level,
	output logic [2:0]        test_output_mux_select,
	output logic [1:0]        prescaler_select,
	output logic [4:0]        swallow_count,
	output logic [12:0]       main_count,
	output logic [17:0]       feedback_ratio,
	output logic              output_halving_enable,
	output logic              halved_feedback_select,
	output logic [13:0]       reference_divide_ratio,
	output logic [1:0]        antibacklash_width,
	output logic              test_latch_active,
	output logic              band_clock
);
	typedef struct packed {
		logic [1:0]  s_sclk;
		logic [1:0]  s_data;
		logic [1:0]  s_le;
		logic [1:0]  s_ce;
		logic [1:0]  s_ref;
		logic [1:0]  s_ph;
		logic        sclk_d;
		logic        le_d;
		logic        ref_d;
		logic [23:0] ctl;
		logic [23:0] fbk;
		logic [23:0] rfw;
		logic [23:0] tst;
		logic        gain;
		logic        pd_sync_arm;
		logic [1:0]  pd_edges;
		logic        pd_latched;
		logic [2:0]  good_cnt;
		logic        locked;
		logic [3:0]  band_div;
		logic        band_clk;
		logic        o_pd;
		logic        o_tri;
		logic        o_pol;
		logic [2:0]  o_cur;
		logic        o_rfen;
		logic        o_refen;
		logic        o_load;
		logic [17:0] o_ratio;
	} plsd_st_t;

	plsd_st_t         st_r;
	plsd_st_t         st_nxt;
	logic [23:0]      shift_q;
	logic             sclk_rise;
	logic             le_rise;
	logic             ref_rise;
	logic             pd_now;
	logic [2:0]       lock_need;
	logic [3:0]       band_lim;

	// prescaler modulus from the select field; encodings beyond the printed pair kept plain
	function automatic logic [4:0] plsd_prescale(input logic [1:0] sel);
		case (sel)
			2'h0:    plsd_prescale = 5'h08;
			2'h1:    plsd_prescale = 5'h10;
			default: plsd_prescale = 5'h10;
		endcase
	endfunction

	// edge detects read only the second synchroniser stage
	assign sclk_rise = st_r.s_sclk[1] & ~st_r.sclk_d;
	assign le_rise   = st_r.s_le[1] & ~st_r.le_d;
	assign ref_rise  = st_r.s_ref[1] & ~st_r.ref_d;

	plsd_shift #(
		.W(WORD_W)
	) u_shift (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.sclk_rise (sclk_rise),
		.sdata     (st_r.s_data[1]),
		.shift_q   (shift_q)
	);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s_sclk = {st_r.s_sclk[0], serial_clock_pin};
		st_nxt.s_data = {st_r.s_data[0], serial_data_pin};
		st_nxt.s_le   = {st_r.s_le[0], serial_latch_strobe};
		st_nxt.s_ce   = {st_r.s_ce[0], chip_enable_pin};
		st_nxt.s_ref  = {st_r.s_ref[0], ref_out_pin};
		st_nxt.s_ph   = {st_r.s_ph[0], phase_err_small_pin};
		st_nxt.sclk_d = st_r.s_sclk[1];
		st_nxt.le_d   = st_r.s_le[1];
		st_nxt.ref_d  = st_r.s_ref[1];

		// word transfer stays live during power-down
		if (le_rise)
		begin
			case (shift_q[1:0])
				SEL_CONTROL:
				begin
					st_nxt.ctl  = shift_q;
					st_nxt.gain = shift_q[CW_GAIN];
					st_nxt.pd_sync_arm = shift_q[CW_PD_EN] & shift_q[CW_PD_SYNC];
					st_nxt.pd_edges = 2'h0;
				end
				SEL_REFERENCE: st_nxt.rfw = shift_q;
				SEL_FEEDBACK:
				begin
					st_nxt.fbk  = shift_q;
					st_nxt.gain = shift_q[FW_GAIN];
				end
				SEL_TEST: st_nxt.tst = shift_q;
				default: st_nxt.tst = st_r.tst;
			endcase
		end

		// synchronous power-down counts reference rises after the strobe
		if (st_r.pd_sync_arm && ref_rise && !le_rise)
		begin
			if (st_r.pd_edges == SYNC_PD_EDGES - 2'h1)
			begin
				st_nxt.pd_latched  = 1'b1;
				st_nxt.pd_sync_arm = 1'b0;
			end
			st_nxt.pd_edges = st_r.pd_edges + 2'h1;
		end
		if (!st_r.ctl[CW_PD_EN])
			st_nxt.pd_latched = 1'b0;

		// lock detect: consecutive reference cycles inside the phase window
		if (pd_now)
		begin
			st_nxt.good_cnt = 3'h0;
			st_nxt.locked   = 1'b0;
		end
		else if (ref_rise)
		begin
			if (!st_r.s_ph[1])
			begin
				st_nxt.good_cnt = 3'h0;
				st_nxt.locked   = 1'b0;
			end
			else if (st_r.good_cnt + 3'h1 >= lock_need)
			begin
				st_nxt.locked   = 1'b1;
				st_nxt.good_cnt = lock_need;
			end
			else
				st_nxt.good_cnt = st_r.good_cnt + 3'h1;
		end

		// band logic clock: toggles once every band_lim+1 reference rises
		// the count moves only on a rise or a power-down clear, so an idle reference reloads it only in power-down
		if (pd_now)
			st_nxt.band_div = 4'h0;
		else if (ref_rise)
		begin
			if (st_r.band_div >= band_lim)
			begin
				st_nxt.band_div = 4'h0;
				st_nxt.band_clk = ~st_r.band_clk;
			end
			else
				st_nxt.band_div = st_r.band_div + 4'h1;
		end

		st_nxt.o_pd    = pd_now;
		st_nxt.o_tri   = pd_now | st_r.ctl[CW_TRI];
		st_nxt.o_pol   = st_r.ctl[CW_POL];
		st_nxt.o_cur   = st_r.gain ? st_r.ctl[CW_CUR2_LO +: 3]
		                           : st_r.ctl[CW_CUR1_LO +: 3];
		st_nxt.o_rfen  = !pd_now && (!st_r.ctl[CW_MUTE] || st_nxt.locked);
		st_nxt.o_refen = !pd_now;
		st_nxt.o_load  = pd_now | st_r.ctl[CW_DIVRST];
		// operands widened first: a 16 x 8191 product overflows the 13-bit field width
		st_nxt.o_ratio = 18'(plsd_prescale(st_r.ctl[CW_PRE_LO +: 2]))
		               * 18'(st_r.fbk[FW_MAIN_LO +: 13])
		               + 18'(st_r.fbk[FW_SWALLOW_LO +: 5]);
	end

	// power-down: pin at once, async mode at once, sync mode once edges counted
	always_comb
	begin
		pd_now = !st_r.s_ce[1]
		       || (st_r.ctl[CW_PD_EN] && !st_r.ctl[CW_PD_SYNC])
		       || st_r.pd_latched;
		lock_need = st_r.rfw[RW_LOCK_PREC] ? LOCK_CYC_FINE : LOCK_CYC_COARSE;
		// divider reload count per band field code; code zero passes every edge
		case (st_r.rfw[RW_BAND_LO +: 2])
			2'h0:    band_lim = 4'h0;
			2'h1:    band_lim = 4'h1;
			2'h2:    band_lim = 4'h3;
			default: band_lim = 4'h7;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign powered_down           = st_r.o_pd;
	assign pump_tristate_out      = st_r.o_tri;
	assign pump_polarity_pos      = st_r.o_pol;
	assign pump_current_sel       = st_r.o_cur;
	assign rf_output_enable       = st_r.o_rfen;
	assign ref_buffer_enable      = st_r.o_refen;
	assign counters_load          = st_r.o_load;
	assign lock_detect            = st_r.locked;
	assign output_power_level     = st_r.ctl[CW_PWR_LO +: 2];
	assign core_power_level       = st_r.ctl[CW_CORE_LO +: 2];
	assign test_output_mux_select = st_r.ctl[CW_MUX_LO +: 3];
	assign prescaler_select       = st_r.ctl[CW_PRE_LO +: 2];
	assign swallow_count          = st_r.fbk[FW_SWALLOW_LO +: 5];
	assign main_count             = st_r.fbk[FW_MAIN_LO +: 13];
	assign feedback_ratio         = st_r.o_ratio;
	assign output_halving_enable  = st_r.fbk[FW_HALVE];
	assign halved_feedback_select = st_r.fbk[FW_HALVE_FB];
	assign reference_divide_ratio = st_r.rfw[RW_RATIO_LO +: 14];
	assign antibacklash_width     = st_r.rfw[RW_ABL_LO +: 2];
	assign test_latch_active      = st_r.rfw[RW_TEST_EN];
	assign band_clock             = st_r.band_clk;
endmodule // plsd_decoder

// *** design/plsd_pkg.sv ***
// plsd_pkg: field layout, word selects and timing constants for the synthesizer latch decoder
// assumes a 10 MHz system clock; serial words are 24 bits, lsb-first positions as printed
package plsd_pkg;
	localparam int WORD_W          = 24;
	// word select codes {c2,c1}
	localparam logic [1:0] SEL_CONTROL   = 2'h0;
	localparam logic [1:0] SEL_REFERENCE = 2'h1;
	localparam logic [1:0] SEL_FEEDBACK  = 2'h2;
	localparam logic [1:0] SEL_TEST      = 2'h3;
	// control word fields
	localparam int CW_CORE_LO      = 2;
	localparam int CW_DIVRST       = 4;
	localparam int CW_MUX_LO       = 5;
	localparam int CW_POL          = 8;
	localparam int CW_TRI          = 9;
	localparam int CW_GAIN         = 10;
	localparam int CW_MUTE         = 11;
	localparam int CW_PWR_LO       = 12;
	localparam int CW_CUR1_LO      = 14;
	localparam int CW_CUR2_LO      = 17;
	localparam int CW_PD_EN        = 20;
	localparam int CW_PD_SYNC      = 21;
	localparam int CW_PRE_LO       = 22;
	// feedback word fields
	localparam int FW_SWALLOW_LO   = 2;
	localparam int FW_MAIN_LO      = 8;
	localparam int FW_GAIN         = 21;
	localparam int FW_HALVE        = 22;
	localparam int FW_HALVE_FB     = 23;
	// reference word fields
	localparam int RW_RATIO_LO     = 2;
	localparam int RW_ABL_LO       = 16;
	localparam int RW_LOCK_PREC    = 18;
	localparam int RW_TEST_EN      = 19;
	localparam int RW_BAND_LO      = 20;
	// lock detect: cycles below the phase window
	localparam logic [2:0] LOCK_CYC_FINE   = 3'h5;
	localparam logic [2:0] LOCK_CYC_COARSE = 3'h3;
	localparam int PHASE_WIN_NS    = 15;
	localparam int CLK_NS          = 100;
	// window rounds down; a 10 MHz clock cannot resolve it, so floor at one cycle
	localparam int PHASE_WIN_CYC   = (PHASE_WIN_NS / CLK_NS) < 1 ? 1 : PHASE_WIN_NS / CLK_NS;
	localparam logic [23:0] RST_WORD = 24'h00_0000;
	localparam logic [12:0] MAIN_MIN = 13'h0003;
	// synchronous power-down waits for this many reference edges after the strobe
	localparam logic [1:0] SYNC_PD_EDGES = 2'h2;
endpackage

// *** design/plsd_shift.sv ***
// plsd_shift: 24-bit serial input register, shifted on rising serial clock samples
// assumes serial inputs are already synchronised to clk; keeps loading in power-down
`timescale 1ns/1ps
module plsd_shift
	import plsd_pkg::*;
#(
	parameter int W = WORD_W
)(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         sclk_rise,
	input  wire logic         sdata,
	output logic [W-1:0]      shift_q
);
	typedef struct packed {
		logic [W-1:0] sr;
	} plsd_shift_st_t;

	plsd_shift_st_t st_r;
	plsd_shift_st_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (sclk_rise)
			st_nxt.sr = {st_r.sr[W-2:0], sdata};
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign shift_q = st_r.sr;
endmodule // plsd_shift

// *** sim/plsd_host.sv ***
// plsd_host: host end of the three-wire link, 24-bit words msb first
// assumes the bench calls send() after reset; pins move on falling edges
`timescale 1ns/1ps
module plsd_host
	import plsd_pkg::*;
(
	input  wire logic clk,
	output logic      sclk,
	output logic      sdata,
	output logic      strobe
);
	// 4 clks per level keeps above the decoder's 3-clk sampling floor
	int hold = 4;
	initial
	begin
		sclk = 1'b0;
		sdata = 1'b0;
		strobe = 1'b0;
	end
	task automatic send(input logic [23:0] w);
		if (w[1:0] == SEL_FEEDBACK)
			w[7] = 1'b0;
		if (w[1:0] == SEL_REFERENCE)
			w[23:19] = {2'h0, w[21:20], 1'b0};
		for (int i = 23; i >= 0; i--)
		begin
			@(negedge clk) sdata = w[i];
			repeat (hold) @(negedge clk);
			sclk = 1'b1;
			repeat (hold) @(negedge clk);
			sclk = 1'b0;
		end
		// released data line shows the inverse, not a stale bit
		sdata = ~sdata;
		strobe = 1'b1;
		repeat (hold) @(negedge clk);
		strobe = 1'b0;
		repeat (hold) @(negedge clk);
	endtask
endmodule // plsd_host

// *** sim/plsd_properties.sv ***
// plsd_props: timing checks of the latch decoder seen at its ports
// assumes pins move on falling clock edges and hold each level 3 clks or more
`timescale 1ns/1ps
module plsd_props (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        serial_latch_strobe,
	input wire logic        chip_enable_pin,
	input wire logic        ref_out_pin,
	input wire logic        phase_err_small_pin,
	input wire logic        powered_down,
	input wire logic        pump_tristate_out,
	input wire logic        rf_output_enable,
	input wire logic        ref_buffer_enable,
	input wire logic        counters_load,
	input wire logic        lock_detect,
	input wire logic [1:0]  prescaler_select,
	input wire logic [4:0]  swallow_count,
	input wire logic [12:0] main_count,
	input wire logic [17:0] feedback_ratio,
	input wire logic        band_clock
);
	typedef struct packed {
		logic       le_q;
		logic       ref_q;
		logic [3:0] le_age;
		logic [3:0] ref_age;
		logic [2:0] good;
	} plsd_chk_t;
	plsd_chk_t st_r, st_nxt;
	// ages count clks since the pin rose; good counts in-window reference edges
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.le_q = serial_latch_strobe;
		st_nxt.ref_q = ref_out_pin;
		st_nxt.le_age = st_r.le_age + {3'h0, st_r.le_age != 4'hF};
		st_nxt.ref_age = st_r.ref_age + {3'h0, st_r.ref_age != 4'hF};
		if (serial_latch_strobe && !st_r.le_q)
			st_nxt.le_age = 4'h0;
		if (ref_out_pin && !st_r.ref_q)
		begin
			st_nxt.ref_age = 4'h0;
			st_nxt.good = phase_err_small_pin ? st_r.good + {2'h0, st_r.good != 3'h7} : 3'h0;
		end
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_r <= '{le_age: 4'hF, ref_age: 4'hF, default: '0};
		else
			st_r <= st_nxt;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_ce_low;
		!chip_enable_pin [*5];
	endsequence
	sequence s_word_fresh;
		st_r.le_age inside {[2:5]};
	endsequence
	a_ce_disable: assert property (s_ce_low |-> powered_down)
		else $error("device stayed up with chip enable low");
	a_pd_pump: assert property (powered_down |-> ##[0:1] (pump_tristate_out && counters_load))
		else $error("pump or counters active in power-down");
	a_pd_buffers: assert property (powered_down |-> ##[0:1] !(ref_buffer_enable || rf_output_enable))
		else $error("buffers on in power-down");
	a_pd_lock: assert property (powered_down |-> ##[0:1] !lock_detect)
		else $error("lock held in power-down");
	a_ratio_sum: assert property (($stable(main_count) && $stable(swallow_count)
		&& $stable(prescaler_select)) |-> feedback_ratio
		== ((prescaler_select == 2'h0 ? 18'h8 : 18'h10) * main_count + swallow_count))
		else $error("feedback ratio mismatch");
	a_field_time: assert property (($changed(main_count) || $changed(swallow_count)) |-> s_word_fresh)
		else $error("feedback fields changed without a latch strobe");
	a_lock_count: assert property ($rose(lock_detect) |-> st_r.good >= 3'h3)
		else $error("lock declared too early");
	a_band_ref: assert property ($changed(band_clock) |-> st_r.ref_age <= 4'h5)
		else $error("band clock moved without a reference edge");
endmodule // plsd_props

bind plsd_decoder plsd_props chk_u (.clk(clk), .sys_rst(sys_rst),
	.serial_latch_strobe(serial_latch_strobe), .chip_enable_pin(chip_enable_pin),
	.ref_out_pin(ref_out_pin), .phase_err_small_pin(phase_err_small_pin),
	.powered_down(powered_down), .pump_tristate_out(pump_tristate_out),
	.rf_output_enable(rf_output_enable), .ref_buffer_enable(ref_buffer_enable),
	.counters_load(counters_load), .lock_detect(lock_detect),
	.prescaler_select(prescaler_select), .swallow_count(swallow_count),
	.main_count(main_count), .feedback_ratio(feedback_ratio), .band_clock(band_clock));

// *** sim/tb.sv ***
// tb: self-checking bench for the synthesizer latch decoder
// assumes plsd_host drives the serial pins; other pins move on falling edges
`timescale 1ns/1ps
module tb;
	logic        clk, sys_rst, sclk, sdata, le, ce, refp, perr;
	logic        pd, tri_o, pol, rf, refbuf, cload, lock, hv, hfb, tla, bclk;
	logic [1:0]  opl, cpl, pre, abl;
	logic [2:0]  cur, mux;
	logic [4:0]  sw;
	logic [12:0] mc;
	logic [13:0] rdr;
	logic [17:0] ratio;
	int          bad_count = 0;
	int          samples_checked = 0;
	plsd_host host_u (.clk(clk), .sclk(sclk), .sdata(sdata), .strobe(le));
	plsd_decoder dut_u (.clk(clk), .sys_rst(sys_rst), .serial_clock_pin(sclk),
		.serial_data_pin(sdata), .serial_latch_strobe(le), .chip_enable_pin(ce),
		.ref_out_pin(refp), .phase_err_small_pin(perr), .powered_down(pd),
		.pump_tristate_out(tri_o), .pump_polarity_pos(pol), .pump_current_sel(cur),
		.rf_output_enable(rf), .ref_buffer_enable(refbuf), .counters_load(cload),
		.lock_detect(lock), .output_power_level(opl), .core_power_level(cpl),
		.test_output_mux_select(mux), .prescaler_select(pre), .swallow_count(sw),
		.main_count(mc), .feedback_ratio(ratio), .output_halving_enable(hv),
		.halved_feedback_select(hfb), .reference_divide_ratio(rdr),
		.antibacklash_width(abl), .test_latch_active(tla), .band_clock(bclk));
	task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic pulse(input int n);
		repeat (n)
		begin
			@(negedge clk) refp = 1'b1;
			repeat (4) @(negedge clk);
			refp = 1'b0;
			repeat (4) @(negedge clk);
		end
	endtask
	task automatic wait_pd(input logic v);
		for (int i = 0; i < 20 && pd !== v; i++)
			@(negedge clk);
	endtask
	task automatic t_fields;
		host_u.send(24'h16_FFFD);
		chk("ref ratio", 18'h3FFF, rdr);
		chk("antibacklash", 18'h2, abl);
		chk("test latch", 18'h0, tla);
		host_u.send(24'h4A_A564);
		chk("current", 18'h5, cur);
		chk("polarity", 18'h1, pol);
		chk("power level", 18'h2, opl);
		chk("mux", 18'h3, mux);
		chk("core", 18'h1, cpl);
		chk("prescaler", 18'h1, pre);
		host_u.hold = 6;
		host_u.send(24'hDF_FF7E);
		chk("swallow", 18'h1F, sw);
		chk("main", 18'h1FFF, mc);
		chk("ratio", 18'h2_000F, ratio);
		chk("halving", 18'h1, hv);
		chk("halved feedback", 18'h1, hfb);
		chk("current fbk gain", 18'h2, cur);
		host_u.hold = 4;
		host_u.send(24'h4A_A564);
		chk("current ctl gain", 18'h5, cur);
		host_u.send(24'h00_0302);
		chk("ratio min", 18'h30, ratio);
		chk("current one", 18'h2, cur);
	endtask
	task automatic t_power;
		host_u.send(24'h5A_A564);
		chk("async pd", 18'h1, pd);
		chk("pd outputs", 18'hA, {tri_o, refbuf, cload, lock});
		host_u.send(24'h4A_A564);
		chk("pd exit", 18'h0, pd);
		host_u.send(24'h7A_A564);
		pulse(1);
		chk("sync pd early", 18'h0, pd);
		pulse(1);
		chk("sync pd", 18'h1, pd);
		host_u.send(24'h4A_A564);
		@(negedge clk) ce = 1'b0;
		wait_pd(1'b1);
		chk("ce off", 18'h1, pd);
		@(negedge clk) ce = 1'b1;
		wait_pd(1'b0);
		chk("ce on", 18'h0, pd);
	endtask
	task automatic t_bits;
		host_u.send(24'h4A_A574);
		chk("divider reset", 18'h1, cload);
		host_u.send(24'h4A_A764);
		chk("pump tristate", 18'h1, tri_o);
		host_u.send(24'h4A_A464);
		chk("polarity neg", 18'h0, pol);
		chk("pump active", 18'h0, tri_o);
		chk("counters run", 18'h0, cload);
	endtask
	task automatic t_lock;
		host_u.send(24'h4A_AD64);
		perr = 1'b0;
		pulse(1);
		perr = 1'b1;
		pulse(4);
		chk("lock 4 of 5", 18'h0, {lock, rf});
		pulse(1);
		chk("lock 5 muted rf", 18'h3, {lock, rf});
		host_u.send(24'h12_FFFD);
		perr = 1'b0;
		pulse(1);
		perr = 1'b1;
		pulse(2);
		chk("lock 2 of 3", 18'h0, lock);
		pulse(1);
		chk("lock 3", 18'h1, lock);
	endtask
	task automatic t_modes;
		logic b0;
		host_u.send(24'h21_0005);
		chk("ref ratio min", 18'h1, rdr);
		chk("antibacklash one", 18'h1, abl);
		host_u.send(24'h07_9088);
		chk("prescaler eight", 18'h0, pre);
		chk("power level one", 18'h1, opl);
		chk("mux four", 18'h4, mux);
		chk("core two", 18'h2, cpl);
		chk("current set one", 18'h6, cur);
		chk("ratio eight", 18'h18, ratio);
		host_u.send(24'hFF_FFFF);
		chk("test word ref", 18'h1, rdr);
		chk("test word ratio", 18'h18, ratio);
		chk("test word current", 18'h6, cur);
		b0 = bclk;
		pulse(4);
		chk("band quarter", {17'h0, ~b0}, bclk);
		pulse(4);
		chk("band period", {17'h0, b0}, bclk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		#3_000_000;
		bad_count++;
		results;
	end
	initial
	begin
		sys_rst = 1'b1;
		ce = 1'b1;
		refp = 1'b0;
		perr = 1'b1;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		t_fields;
		t_power;
		t_bits;
		t_lock;
		t_modes;
		results;
	end
endmodule // tb
